// *** hdl/swc_poll_timer.sv ***
`include "swc_map.svh"
`default_nettype none
module swc_poll_timer #(
   parameter int TICK_CYCLES = `SWC_TICK_CYC
) (
   input wire logic ref_clk,
   input wire logic srst_n,
   input wire logic run,
   input wire logic poll_en,
   input wire logic [3:0] code,
   output swc_pkg::swc_ms_t interval_q,
   output logic poll_start_q
);
   logic [15:0] pre_q;
   logic [15:0] pre_d;
   swc_pkg::swc_ms_t ms_q;
   swc_pkg::swc_ms_t ms_d;
   swc_pkg::swc_ms_t interval_d;
   logic active;
   logic ms_tick;
   logic period_done;

   // ----------------------------------------------------------------
   // Interval decode
   // ----------------------------------------------------------------
   always_comb begin
      case (code)
         4'h0: interval_d = 13'h0002;
         4'h1: interval_d = 13'h0004;
         4'h2: interval_d = 13'h0008;
         4'h3: interval_d = 13'h0010;
         4'h4: interval_d = 13'h0020;
         4'h5: interval_d = 13'h0030;
         4'h6: interval_d = 13'h0040;
         4'h7: interval_d = 13'h0080;
         4'h8: interval_d = 13'h0100;
         4'h9: interval_d = 13'h0200;
         4'ha: interval_d = 13'h0400;
         4'hb: interval_d = 13'h0800;
         4'hc: interval_d = 13'h1000;
         default: interval_d = `SWC_PT_DEFAULT_MS;
      endcase
   end

   // ----------------------------------------------------------------
   // Millisecond prescaler and interval counter
   // ----------------------------------------------------------------
   assign active = run & poll_en;
   assign ms_tick = active && (pre_q == 16'(TICK_CYCLES - 1));
   assign period_done = ms_tick && (ms_q == interval_q - 13'h0001);
   assign pre_d = (!active || ms_tick) ? 16'h0000 : pre_q + 16'h0001;
   assign ms_d = (!active || period_done) ? 13'h0000 : (ms_tick ? ms_q + 13'h0001 : ms_q);

   always_ff @(posedge ref_clk) begin
      if (!srst_n) begin
         pre_q <= 16'h0000;
         ms_q <= 13'h0000;
         interval_q <= 13'h0002;
         poll_start_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         ms_q <= ms_d;
         interval_q <= interval_d;
         poll_start_q <= period_done;
      end
   end

   a_code_fallback: assert property (@(posedge ref_clk) disable iff (!srst_n)
      code >= 4'hd |=> interval_q == 13'h0008)
      else $error("reserved interval code not 8 ms");
   a_poll_gated: assert property (@(posedge ref_clk) disable iff (!srst_n)
      poll_start_q |-> $past(run) && $past(poll_en))
      else $error("poll start without periodic mode");
   c_poll_start: cover property (@(posedge ref_clk) disable iff (!srst_n) poll_start_q);
endmodule
`default_nettype wire

// *** hdl/swc_top.sv ***
// Operation
// - Interval code picks 2..4096 ms, else 8.
// - Control bit 0 written one resets device.
// - Enabled channels polled, disabled channels skipped.
// - Channel enables reset to all zero.
// - Direction bits 9..0 select sink; rest zero.
// - Wetting codes map to 0..15 mA; reset none.
// - Own codes for inputs 11,10,5,4.
// - Pairs 8/9 and 6/7 share codes.
// - Interval applies only with periodic mode set.
`include "swc_map.svh"
`default_nettype none
module swc_top #(
   parameter int TICK_CYCLES = `SWC_TICK_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [23:0] reg_wdata,
   output logic [23:0] reg_rdata,
   output logic reg_rvalid,
   output logic [23:0] chan_enable,
   output logic [9:0] current_source_mode,
   output logic [47:0] wet_ma,
   output logic [12:0] interval_ms,
   output logic run_active,
   output logic poll_mode,
   output logic poll_start,
   output logic [4:0] active_chan,
   output logic active_valid,
   output logic sw_reset_pulse
);
   logic [23:0] ctrl_q;
   logic [23:0] inen_q;
   logic [23:0] csel_q;
   logic [23:0] wcl_q;
   logic sw_reset_q;
   logic [23:0] rdata_q;
   logic [23:0] rdata_d;
   logic rvalid_q;
   logic srst_n;
   logic wr_ctrl;
   logic wr_inen;
   logic wr_csel;
   logic wr_wcl;
   logic run;
   logic pen;
   logic [3:0] pt_code;
   logic poll_start_w;
   logic [12:0] interval_w;
   swc_pkg::swc_seq_e state_q;
   swc_pkg::swc_seq_e state_d;
   logic [4:0] idx_q;
   logic [4:0] idx_d;
   logic [4:0] chan_q;
   logic chan_valid_q;
   logic scan_last;
   logic start_scan;
   logic [35:0] wcode;

   // ----------------------------------------------------------------
   // Reset and address decode
   // ----------------------------------------------------------------
   assign srst_n = resetn & ~sw_reset_q;
   assign wr_ctrl = reg_wr && (reg_addr == `SWC_ADDR_CTRL);
   assign wr_inen = reg_wr && (reg_addr == `SWC_ADDR_INEN);
   assign wr_csel = reg_wr && (reg_addr == `SWC_ADDR_CSEL);
   assign wr_wcl = reg_wr && (reg_addr == `SWC_ADDR_WCL);
   assign run = ctrl_q[`SWC_CTRL_TRIG_BIT];
   assign pen = ctrl_q[`SWC_CTRL_PEN_BIT];
   assign pt_code = ctrl_q[`SWC_CTRL_PT_MSB:`SWC_CTRL_PT_LSB];

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sw_reset_q <= 1'b0;
      end else begin
         sw_reset_q <= wr_ctrl && reg_wdata[`SWC_CTRL_RST_BIT] && !sw_reset_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!srst_n) begin
         ctrl_q <= `SWC_REG_RST;
         inen_q <= `SWC_REG_RST;
         csel_q <= `SWC_REG_RST;
         wcl_q <= `SWC_REG_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= reg_wdata & `SWC_CTRL_RMASK & ~24'h000001;
         end
         if (wr_inen) begin
            inen_q <= reg_wdata;
         end
         if (wr_csel) begin
            csel_q <= reg_wdata & `SWC_CSEL_WMASK;
         end
         if (wr_wcl) begin
            wcl_q <= reg_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      case (reg_addr)
         `SWC_ADDR_CTRL: rdata_d = ctrl_q | {23'h000000, sw_reset_q};
         `SWC_ADDR_INEN: rdata_d = inen_q;
         `SWC_ADDR_CSEL: rdata_d = csel_q & `SWC_CSEL_WMASK;
         `SWC_ADDR_WCL: rdata_d = wcl_q;
         default: rdata_d = 24'h000000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rdata_q <= 24'h000000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd;
         if (reg_rd) begin
            rdata_q <= rdata_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // Wetting level codes per input
   // ----------------------------------------------------------------
   assign wcode[2:0] = wcl_q[`SWC_WL_P01_LSB +: 3];
   assign wcode[5:3] = wcl_q[`SWC_WL_P01_LSB +: 3];
   assign wcode[8:6] = wcl_q[`SWC_WL_P23_LSB +: 3];
   assign wcode[11:9] = wcl_q[`SWC_WL_P23_LSB +: 3];
   assign wcode[14:12] = wcl_q[`SWC_WL_IN4_LSB +: 3];
   assign wcode[17:15] = wcl_q[`SWC_WL_IN5_LSB +: 3];
   assign wcode[20:18] = wcl_q[`SWC_WL_P67_LSB +: 3];
   assign wcode[23:21] = wcl_q[`SWC_WL_P67_LSB +: 3];
   assign wcode[26:24] = wcl_q[`SWC_WL_P89_LSB +: 3];
   assign wcode[29:27] = wcl_q[`SWC_WL_P89_LSB +: 3];
   assign wcode[32:30] = wcl_q[`SWC_WL_IN10_LSB +: 3];
   assign wcode[35:33] = wcl_q[`SWC_WL_IN11_LSB +: 3];

   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_wet
         swc_wet_decode u_dec (
            .ref_clk(ref_clk),
            .srst_n(srst_n),
            .code(wcode[gi*3 +: 3]),
            .ma_q(wet_ma[gi*4 +: 4])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Poll interval timer
   // ----------------------------------------------------------------
   swc_poll_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .ref_clk(ref_clk),
      .srst_n(srst_n),
      .run(run),
      .poll_en(pen),
      .code(pt_code),
      .interval_q(interval_w),
      .poll_start_q(poll_start_w)
   );

   // ----------------------------------------------------------------
   // Channel sequencer
   // ----------------------------------------------------------------
   // Stopping the run bit aborts a scan; config is then safe to change
   assign start_scan = run && (!pen || poll_start_w);
   assign scan_last = (idx_q == 5'd23);

   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      case (state_q)
         swc_pkg::SWC_IDLE: begin
            idx_d = 5'd0;
            if (start_scan) begin
               state_d = swc_pkg::SWC_SCAN;
            end
         end
         swc_pkg::SWC_SCAN: begin
            idx_d = 5'(idx_q + 5'd1);
            if (!run || scan_last) begin
               state_d = swc_pkg::SWC_IDLE;
               idx_d = 5'd0;
            end
         end
         default: begin
            state_d = swc_pkg::SWC_IDLE;
            idx_d = 5'd0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!srst_n) begin
         state_q <= swc_pkg::SWC_IDLE;
         idx_q <= 5'd0;
         chan_q <= 5'd0;
         chan_valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         chan_q <= idx_q;
         chan_valid_q <= (state_q == swc_pkg::SWC_SCAN) && run && inen_q[idx_q];
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign chan_enable = inen_q;
   assign current_source_mode = csel_q[9:0];
   assign interval_ms = interval_w;
   assign run_active = run;
   assign poll_mode = pen;
   assign poll_start = poll_start_w;
   assign active_chan = chan_q;
   assign active_valid = chan_valid_q;
   assign sw_reset_pulse = sw_reset_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_swrst_once: assert property (@(posedge ref_clk) disable iff (!resetn)
      sw_reset_q |=> !sw_reset_q)
      else $error("software reset not a single pulse");
   a_swrst_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(sw_reset_q) |-> $past(wr_ctrl) && $past(reg_wdata[0]))
      else $error("software reset without write of one");
   a_rst_bit_low: assert property (@(posedge ref_clk) disable iff (!resetn)
      ctrl_q[`SWC_CTRL_RST_BIT] == 1'b0)
      else $error("reset request bit kept in control");
   a_swrst_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      sw_reset_q |=> inen_q == 24'h0 && csel_q == 24'h0 && wcl_q == 24'h0
      && ctrl_q == 24'h0)
      else $error("software reset left register content");
   a_enable_reset: assert property (@(posedge ref_clk)
      !resetn |=> inen_q == 24'h000000 && state_q == swc_pkg::SWC_IDLE)
      else $error("enables not cleared by reset");
   a_inen_store: assert property (@(posedge ref_clk) disable iff (!srst_n)
      wr_inen |=> sw_reset_q || inen_q == $past(reg_wdata))
      else $error("enable write not stored");
   a_csel_store: assert property (@(posedge ref_clk) disable iff (!srst_n)
      wr_csel |=> sw_reset_q || csel_q == {14'h0, $past(reg_wdata[9:0])})
      else $error("direction write not stored");
   a_csel_reserved: assert property (@(posedge ref_clk) disable iff (!resetn)
      rvalid_q && $past(reg_addr) == 6'h1c |-> reg_rdata[23:10] == 14'h0)
      else $error("reserved direction bits read nonzero");
   a_wcl_store: assert property (@(posedge ref_clk) disable iff (!srst_n)
      wr_wcl |=> sw_reset_q || wcl_q == $past(reg_wdata))
      else $error("wetting write not stored");
   a_skip_disabled: assert property (@(posedge ref_clk) disable iff (!srst_n)
      chan_valid_q |-> $past(inen_q[idx_q]) && $past(state_q) == swc_pkg::SWC_SCAN)
      else $error("disabled channel was polled");
   a_enabled_hit: assert property (@(posedge ref_clk) disable iff (!srst_n)
      state_q == swc_pkg::SWC_SCAN && run && inen_q[idx_q] && !sw_reset_q
      |=> chan_valid_q && chan_q == $past(idx_q))
      else $error("enabled channel missed");
   a_run_abort: assert property (@(posedge ref_clk) disable iff (!srst_n)
      state_q == swc_pkg::SWC_SCAN && !run
      |=> state_q == swc_pkg::SWC_IDLE && !chan_valid_q)
      else $error("scan kept running after stop");
   a_scan_wrap: assert property (@(posedge ref_clk) disable iff (!srst_n)
      state_q == swc_pkg::SWC_SCAN && scan_last |=> state_q == swc_pkg::SWC_IDLE)
      else $error("scan ran past last channel");
   a_cont_mode: assert property (@(posedge ref_clk) disable iff (!srst_n)
      state_q == swc_pkg::SWC_IDLE && run && !pen |=> sw_reset_q
      || state_q == swc_pkg::SWC_SCAN)
      else $error("continuous mode did not scan");
   a_poll_wait: assert property (@(posedge ref_clk) disable iff (!srst_n)
      state_q == swc_pkg::SWC_IDLE && run && pen && !poll_start_w
      |=> state_q == swc_pkg::SWC_IDLE)
      else $error("periodic mode scanned without poll start");
   a_pair_share: assert property (@(posedge ref_clk) disable iff (!srst_n)
      wet_ma[27:24] == wet_ma[31:28] && wet_ma[35:32] == wet_ma[39:36])
      else $error("paired inputs differ in current");
   a_scan_len: assert property (@(posedge ref_clk) disable iff (!srst_n)
      $rose(state_q == swc_pkg::SWC_SCAN) && run ##1 run [*8]
      |-> state_q == swc_pkg::SWC_SCAN)
      else $error("scan ended early");
   c_swrst: cover property (@(posedge ref_clk) disable iff (!resetn) sw_reset_q);
   c_valid: cover property (@(posedge ref_clk) disable iff (!srst_n) chan_valid_q);
   c_scan_end: cover property (@(posedge ref_clk) disable iff (!srst_n)
      state_q == swc_pkg::SWC_SCAN && scan_last);
   c_poll_scan: cover property (@(posedge ref_clk) disable iff (!srst_n)
      state_q == swc_pkg::SWC_IDLE && start_scan && pen);
endmodule
`default_nettype wire

// *** hdl/swc_wet_decode.sv ***
`include "swc_map.svh"
`default_nettype none
module swc_wet_decode (
   input wire logic ref_clk,
   input wire logic srst_n,
   input wire logic [2:0] code,
   output swc_pkg::swc_ma_t ma_q
);
   swc_pkg::swc_ma_t ma_d;

   // ----------------------------------------------------------------
   // Code to current
   // ----------------------------------------------------------------
   always_comb begin
      case (code)
         3'h0: ma_d = `SWC_MA_NONE;
         3'h1: ma_d = `SWC_MA_1;
         3'h2: ma_d = `SWC_MA_2;
         3'h3: ma_d = `SWC_MA_5;
         3'h4: ma_d = `SWC_MA_10;
         default: ma_d = `SWC_MA_15;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!srst_n) begin
         ma_q <= `SWC_MA_NONE;
      end else begin
         ma_q <= ma_d;
      end
   end

   a_wet_high: assert property (@(posedge ref_clk) disable iff (!srst_n)
      code >= 3'h5 |=> ma_q == 4'hf)
      else $error("high code not decoded to 15 mA");
endmodule
`default_nettype wire

// *** pkg/swc_map.svh ***
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SWC_ADDR_CTRL 6'h1a
`define SWC_ADDR_INEN 6'h1b
`define SWC_ADDR_CSEL 6'h1c
`define SWC_ADDR_WCL 6'h1d
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define SWC_CTRL_RST_BIT 0
`define SWC_CTRL_PT_LSB 1
`define SWC_CTRL_PT_MSB 4
`define SWC_CTRL_PEN_BIT 10
`define SWC_CTRL_TRIG_BIT 11
`define SWC_CTRL_RMASK 24'h000c1f
`define SWC_CSEL_WMASK 24'h0003ff
`define SWC_REG_RST 24'h000000
// ----------------------------------------------------------------
// Wetting level field positions
// ----------------------------------------------------------------
`define SWC_WL_IN11_LSB 21
`define SWC_WL_IN10_LSB 18
`define SWC_WL_P89_LSB 15
`define SWC_WL_P67_LSB 12
`define SWC_WL_IN5_LSB 9
`define SWC_WL_IN4_LSB 6
`define SWC_WL_P23_LSB 3
`define SWC_WL_P01_LSB 0
// ----------------------------------------------------------------
// Wetting current in mA
// ----------------------------------------------------------------
`define SWC_MA_NONE 4'h0
`define SWC_MA_1 4'h1
`define SWC_MA_2 4'h2
`define SWC_MA_5 4'h5
`define SWC_MA_10 4'ha
`define SWC_MA_15 4'hf
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SWC_CLK_HZ 40000000
`define SWC_TICK_US 1000
`define SWC_TICK_CYC (`SWC_CLK_HZ / 1000000 * `SWC_TICK_US)
`define SWC_PT_DEFAULT_MS 13'h0008
`endif

// *** pkg/swc_pkg.sv ***
`default_nettype none
package swc_pkg;
   typedef enum logic [1:0] {
      SWC_IDLE = 2'b01,
      SWC_SCAN = 2'b10
   } swc_seq_e;
   typedef logic [3:0] swc_ma_t;
   typedef logic [12:0] swc_ms_t;
endpackage
`default_nettype wire

// *** verif/swc_host_model.sv ***
`default_nettype none
module swc_host_model (
   input wire logic ref_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [5:0] reg_addr,
   output logic [23:0] reg_wdata,
   input wire logic [23:0] reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 24'h000000;
   end

   // -------------------------------------------------
   // Register access, one strobe cycle per request
   // -------------------------------------------------
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      // Idle lines must not keep the last word
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic v);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      // Answer stands for the one cycle after the taking edge
      @(posedge ref_clk);
      d = reg_rdata;
      v = reg_rvalid;
   endtask
endmodule
`default_nettype wire

// *** verif/swc_top_bench.sv ***
`include "swc_map.svh"
`default_nettype none
module swc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 4;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid, run_active, poll_mode, poll_start;
   logic active_valid, sw_reset_pulse, rv;
   logic [5:0] reg_addr;
   logic [23:0] reg_wdata, reg_rdata, chan_enable, rd_q;
   logic [23:0] seen = 24'h000000;
   logic [9:0] current_source_mode;
   logic [47:0] wet_ma;
   logic [12:0] interval_ms;
   logic [4:0] active_chan;
   int fail_count = 0;
   int checked = 0;
   int since = 0;
   int gap = 0;
   logic [12:0] ms_tab [16] = '{13'h0002, 13'h0004, 13'h0008, 13'h0010, 13'h0020,
      13'h0030, 13'h0040, 13'h0080, 13'h0100, 13'h0200, 13'h0400, 13'h0800,
      13'h1000, 13'h0008, 13'h0008, 13'h0008};
   int wl_lsb [12] = '{0, 0, 3, 3, 6, 9, 12, 12, 15, 15, 18, 21};

   always #12.5 ref_clk = ~ref_clk;

   swc_top #(.TICK_CYCLES(TICK)) dut (.ref_clk(ref_clk), .resetn(resetn),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chan_enable(chan_enable),
      .current_source_mode(current_source_mode), .wet_ma(wet_ma),
      .interval_ms(interval_ms), .run_active(run_active), .poll_mode(poll_mode),
      .poll_start(poll_start), .active_chan(active_chan), .active_valid(active_valid),
      .sw_reset_pulse(sw_reset_pulse));

   swc_host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));

   // -------------------------------------------------
   // Monitors: visited channels and poll spacing
   // -------------------------------------------------
   always @(posedge ref_clk) begin
      if (active_valid === 1'b1) begin
         seen[active_chan] <= 1'b1;
      end
      if (poll_start === 1'b1) begin
         gap <= since + 1;
         since <= 0;
      end else begin
         since <= since + 1;
      end
   end

   // -------------------------------------------------
   // Helpers
   // -------------------------------------------------
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
      host.rd(a, rd_q, rv);
      check({rv, rd_q}, {1'b1, exp});
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   function automatic swc_pkg::swc_ma_t ma(input logic [2:0] c);
      case (c)
         3'h0: return 4'h0;
         3'h1: return 4'h1;
         3'h2: return 4'h2;
         3'h3: return 4'h5;
         3'h4: return 4'ha;
         default: return 4'hf;
      endcase
   endfunction

   function automatic logic [47:0] wet_exp(input logic [23:0] w);
      logic [47:0] r;
      for (int n = 0; n < 12; n++) begin
         r[4*n +: 4] = ma(w[wl_lsb[n] +: 3]);
      end
      return r;
   endfunction

   task automatic wet_word(input logic [23:0] w);
      host.wr(`SWC_ADDR_WCL, w);
      rd_chk(`SWC_ADDR_WCL, w);
      check(wet_ma, wet_exp(w));
   endtask

   task automatic finish_test;
      if (fail_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // -------------------------------------------------
   // Test sequence
   // -------------------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      wait_cyc(1);
      check(interval_ms, 13'h0002);
      check(wet_ma, 48'h0);
      rd_chk(`SWC_ADDR_CTRL, 24'h000000);
      rd_chk(`SWC_ADDR_INEN, 24'h000000);
      rd_chk(`SWC_ADDR_CSEL, 24'h000000);
      rd_chk(`SWC_ADDR_WCL, 24'h000000);
      rd_chk(6'h3f, 24'h000000);
      for (int c = 0; c < 16; c++) begin
         host.wr(`SWC_ADDR_CTRL, {19'h0, c[3:0], 1'b0});
         wait_cyc(2);
         check(interval_ms, ms_tab[c]);
      end
      host.wr(`SWC_ADDR_CTRL, 24'hfff3fe);
      rd_chk(`SWC_ADDR_CTRL, 24'h00001e);
      host.wr(`SWC_ADDR_CSEL, 24'hffffff);
      rd_chk(`SWC_ADDR_CSEL, 24'h0003ff);
      check(current_source_mode, 10'h3ff);
      host.wr(`SWC_ADDR_CSEL, 24'hfc0155);
      rd_chk(`SWC_ADDR_CSEL, 24'h000155);
      check(current_source_mode, 10'h155);
      for (int c = 0; c < 8; c++) begin
         wet_word({8{c[2:0]}});
      end
      wet_word({3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0});
      // Configure while stopped, then run continuously
      host.wr(`SWC_ADDR_INEN, 24'h800005);
      rd_chk(`SWC_ADDR_INEN, 24'h800005);
      check(chan_enable, 24'h800005);
      host.wr(`SWC_ADDR_CTRL, 24'h000800);
      wait_cyc(60);
      check(seen, 24'h800005);
      check({run_active, poll_mode}, 2'b10);
      host.wr(`SWC_ADDR_CTRL, 24'h000000);
      // Periodic mode with a 4 ms interval
      host.wr(`SWC_ADDR_CTRL, 24'h000c02);
      wait_cyc(70);
      check(interval_ms, 13'h0004);
      check(48'(gap), 48'h10);
      check({run_active, poll_mode}, 2'b11);
      host.wr(`SWC_ADDR_CTRL, 24'h000000);
      rd_chk(`SWC_ADDR_INEN, 24'h800005);
      host.wr(`SWC_ADDR_CTRL, 24'h000019);
      #1;
      check(sw_reset_pulse, 1'b1);
      rd_chk(`SWC_ADDR_CTRL, 24'h000000);
      check(sw_reset_pulse, 1'b0);
      rd_chk(`SWC_ADDR_INEN, 24'h000000);
      rd_chk(`SWC_ADDR_CSEL, 24'h000000);
      rd_chk(`SWC_ADDR_WCL, 24'h000000);
      check(interval_ms, 13'h0002);
      check(wet_ma, 48'h0);
      finish_test();
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      $display("FAIL %0t timeout", $time);
      finish_test();
   end
endmodule
`default_nettype wire
